/* lbw_regs.svh */
// Register map and timing constants of the LAN bypass watchdog
`ifndef LBW_REGS_SVH
`define LBW_REGS_SVH

// Register indices; byte address is four times the index
`define LBW_IDX_PON      12'h8e0
`define LBW_IDX_POFF     12'h8e1
`define LBW_IDX_TMR      12'h8e2
`define LBW_ADR_W        14

// Field positions
`define LBW_MODE_HI      7
`define LBW_MODE_LO      6
`define LBW_SEG_HI       3
`define LBW_SEG_LO       0
`define LBW_EXP_BIT      7
`define LBW_TSEL_HI      2
`define LBW_TSEL_LO      0

// Reset values
`define LBW_PON_RST      8'h00
`define LBW_POFF_RST     4'h0
`define LBW_TSEL_RST     3'h0
`define LBW_TSEL_OFF     3'h0

// Timing
`define LBW_CLK_HZ       40000000
`define LBW_TICK_SEC     1

`endif

/* lbw_pkg.sv */
// Types shared by the LAN bypass watchdog
`default_nettype none
package lbw_pkg;
  typedef logic [3:0] lbw_seg_t;
  typedef logic [2:0] lbw_tsel_t;
  typedef enum logic [1:0] {
    LBW_MODE_NONE,
    LBW_MODE_FORCE_ON,
    LBW_MODE_FORCE_OFF,
    LBW_MODE_TIMER
  } lbw_mode_t;
  typedef enum {
    LBW_WD_IDLE,
    LBW_WD_RUN,
    LBW_WD_EXPIRED
  } lbw_wd_t;
endpackage
`default_nettype wire

/* lbw_top.sv */
// LAN bypass relay controller with software watchdog, Wishbone slave
//
// Design decision made here: register access over Wishbone.
`default_nettype none
`include "lbw_regs.svh"

// How it works
// - Mode bits 7:6; code 00 idle, code 01 closes relays on masked segments
// - Mode code 10 opens relays on masked segments at once
// - Mode code 11 leaves masked segments to the watchdog timer
// - Power-on mask bits 3:0 pick segments; zero bits leave segments alone
// - Reads of the control registers change nothing and return undefined data
// - Power-on control register clears when system power goes off
// - Without a new power-on write, relays keep the power-off state
// - Power-off mask bits 3:0 set each relay while the system is off
// - Power-off mask survives power-off
// - All three registers reset to zero
// - Timer register bit 7 reads one once the watchdog expired
// - Timeout code n selects two to the n minus one seconds
// - Timeout code 000 keeps the watchdog stopped
// - Writing the timeout restarts counting from the new period
// - Expiry closes relays on segments of the power-on mask
// - Timer register reads never refresh the watchdog; bits 6:0 undefined
// - Relay of segment n joins ports 2n and 2n+1
module lbw_top #(
  parameter int unsigned TICK_CYCLES = `LBW_CLK_HZ * `LBW_TICK_SEC
) (
  // System
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             system_powered,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [15:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output var  logic [31:0]      wb_dat_o,
  output var  logic             wb_ack_o,
  // Relays and status
  output var  lbw_pkg::lbw_seg_t relay_close,
  output var  logic             timer_expired
);
  import lbw_pkg::*;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Pure address match; callers gate it with the bus request
  function automatic logic hit(input logic [15:0] adr, input logic [11:0] idx);
    hit = (adr == {idx, 2'b00});
  endfunction

  logic req;
  logic wr_en;
  logic wr_pon;
  logic wr_poff;
  logic wr_tmr;

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = req && wb_we_i && wb_sel_i[0];
  assign wr_pon  = wr_en && hit(wb_adr_i, `LBW_IDX_PON);
  assign wr_poff = wr_en && hit(wb_adr_i, `LBW_IDX_POFF);
  assign wr_tmr  = wr_en && hit(wb_adr_i, `LBW_IDX_TMR);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  lbw_mode_t bypass_mode_sel;
  lbw_seg_t  poweron_segment_mask;
  lbw_seg_t  poweroff_segment_mask;
  lbw_tsel_t timeout_select;
  logic      powered_q;
  logic      power_fall;

  assign power_fall = powered_q && !system_powered;

  always_ff @(posedge clk) begin
    if (reset) begin
      powered_q <= 1'b0;
    end else begin
      powered_q <= system_powered;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bypass_mode_sel      <= lbw_mode_t'(2'(`LBW_PON_RST >> `LBW_MODE_LO));
      poweron_segment_mask <= lbw_seg_t'(`LBW_PON_RST);
    end else if (power_fall) begin
      bypass_mode_sel      <= LBW_MODE_NONE;
      poweron_segment_mask <= lbw_seg_t'(`LBW_PON_RST);
    end else if (wr_pon) begin
      bypass_mode_sel      <= lbw_mode_t'(wb_dat_i[`LBW_MODE_HI:`LBW_MODE_LO]);
      poweron_segment_mask <= wb_dat_i[`LBW_SEG_HI:`LBW_SEG_LO];
    end
  end

  // Kept through power-off, only system reset clears it
  always_ff @(posedge clk) begin
    if (reset) begin
      poweroff_segment_mask <= `LBW_POFF_RST;
    end else if (wr_poff) begin
      poweroff_segment_mask <= wb_dat_i[`LBW_SEG_HI:`LBW_SEG_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timeout_select <= `LBW_TSEL_RST;
    end else if (wr_tmr) begin
      timeout_select <= wb_dat_i[`LBW_TSEL_HI:`LBW_TSEL_LO];
    end
  end

  // ------------------------------------------------------------
  // One-second tick
  // ------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        sec_tick;

  assign sec_tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (reset || wr_tmr || !system_powered) begin
      tick_cnt <= 32'h0;
    end else if (sec_tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  function automatic logic [6:0] period_sec(input lbw_tsel_t code);
    period_sec = 7'h1 << (code - 3'h1);
  endfunction

  lbw_wd_t    wd_state;
  lbw_wd_t    next_wd_state;
  logic [6:0] sec_cnt;
  logic       expire;

  assign expire = (wd_state == LBW_WD_RUN) && sec_tick && !wr_tmr &&
                  (sec_cnt == period_sec(timeout_select) - 7'h1);

  always_comb begin
    next_wd_state = wd_state;
    case (wd_state)
      LBW_WD_IDLE: begin
        if (wr_tmr && wb_dat_i[`LBW_TSEL_HI:`LBW_TSEL_LO] != `LBW_TSEL_OFF) begin
          next_wd_state = LBW_WD_RUN;
        end
      end
      LBW_WD_RUN, LBW_WD_EXPIRED: begin
        if (wr_tmr) begin
          if (wb_dat_i[`LBW_TSEL_HI:`LBW_TSEL_LO] == `LBW_TSEL_OFF) begin
            next_wd_state = LBW_WD_IDLE;
          end else begin
            next_wd_state = LBW_WD_RUN;
          end
        end else if (expire) begin
          next_wd_state = LBW_WD_EXPIRED;
        end
      end
      default: begin
        next_wd_state = LBW_WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset || power_fall) begin
      wd_state <= LBW_WD_IDLE;
    end else begin
      wd_state <= next_wd_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || wr_tmr) begin
      sec_cnt <= 7'h0;
    end else if (wd_state == LBW_WD_RUN && sec_tick) begin
      sec_cnt <= sec_cnt + 7'h1;
    end
  end

  // Expiry sets the flag; a timeout write in the same cycle suppresses expiry
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_expired <= 1'b0;
    end else if (expire) begin
      timer_expired <= 1'b1;
    end else if (wr_tmr) begin
      timer_expired <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Relays; bit n joins ports 2n and 2n+1
  // ------------------------------------------------------------
  lbw_seg_t next_relay;

  always_comb begin
    next_relay = relay_close;
    if (!system_powered) begin
      next_relay = poweroff_segment_mask;
    end else if (expire) begin
      next_relay = relay_close | poweron_segment_mask;
    end else if (wr_pon) begin
      case (lbw_mode_t'(wb_dat_i[`LBW_MODE_HI:`LBW_MODE_LO]))
        LBW_MODE_FORCE_ON: begin
          next_relay = relay_close | wb_dat_i[`LBW_SEG_HI:`LBW_SEG_LO];
        end
        LBW_MODE_FORCE_OFF: begin
          next_relay = relay_close & ~wb_dat_i[`LBW_SEG_HI:`LBW_SEG_LO];
        end
        default: begin
          next_relay = relay_close;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      relay_close <= lbw_seg_t'(`LBW_POFF_RST);
    end else begin
      relay_close <= next_relay;
    end
  end

  // ------------------------------------------------------------
  // Bus answer; reads have no side effect
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i && hit(wb_adr_i, `LBW_IDX_TMR)) begin
      wb_dat_o <= 32'(timer_expired) << `LBW_EXP_BIT;
    end else begin
      wb_dat_o <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_force_on;
    wr_pon && system_powered && !expire &&
    wb_dat_i[`LBW_MODE_HI:`LBW_MODE_LO] == 2'h1;
  endsequence

  sequence s_force_off;
    wr_pon && system_powered && !expire &&
    wb_dat_i[`LBW_MODE_HI:`LBW_MODE_LO] == 2'h2;
  endsequence

  a_force_on_close: assert property (
    s_force_on |=> ((relay_close & $past(wb_dat_i[3:0])) == $past(wb_dat_i[3:0])))
    else $error("force bypass did not close relays");

  a_force_off_open: assert property (
    s_force_off |=> ((relay_close & $past(wb_dat_i[3:0])) == 4'h0))
    else $error("force disable did not open relays");

  a_timer_mode_hold: assert property (
    (wr_pon && system_powered && !expire &&
     wb_dat_i[`LBW_MODE_HI:`LBW_MODE_LO] == 2'h3) |=> $stable(relay_close))
    else $error("timer mode acted at once");

  a_pon_clear_off: assert property (
    power_fall |=> (poweron_segment_mask == 4'h0 && bypass_mode_sel == LBW_MODE_NONE))
    else $error("power-on register survived power-off");

  a_off_follows_mask: assert property (
    !system_powered |=> relay_close == $past(poweroff_segment_mask))
    else $error("relays not at power-off mask");

  a_off_mask_kept: assert property (
    (!wr_poff && !$past(reset)) |=> $stable(poweroff_segment_mask))
    else $error("power-off mask changed without write");

  a_expire_flag: assert property (
    (expire && system_powered) |=> timer_expired ##0
      ((relay_close & $past(poweron_segment_mask)) == $past(poweron_segment_mask)))
    else $error("expiry did not set flag and close relays");

  a_zero_no_expire: assert property (
    (timeout_select == 3'h0 && !wr_tmr) |-> !expire)
    else $error("disabled watchdog expired");

  a_write_restart: assert property (
    wr_tmr |=> (sec_cnt == 7'h0 && tick_cnt == 32'h0 && !timer_expired))
    else $error("timeout write did not restart watchdog");

  a_read_no_refresh: assert property (
    (req && !wb_we_i && wd_state == LBW_WD_RUN && sec_tick) |=> sec_cnt == $past(sec_cnt) + 7'h1)
    else $error("read refreshed the watchdog");

  sequence s_tmr_read;
    req && !wb_we_i && hit(wb_adr_i, `LBW_IDX_TMR);
  endsequence

  sequence s_other_read;
    req && !wb_we_i && !hit(wb_adr_i, `LBW_IDX_TMR);
  endsequence

  sequence s_zero_write;
    wr_tmr && wb_dat_i[`LBW_TSEL_HI:`LBW_TSEL_LO] == `LBW_TSEL_OFF;
  endsequence

  sequence s_restart_write;
    wr_tmr && !power_fall && wb_dat_i[`LBW_TSEL_HI:`LBW_TSEL_LO] != `LBW_TSEL_OFF;
  endsequence

  a_reset_all_zero: assert property (
    $past(reset) |-> (relay_close == 4'h0 && !timer_expired && !wb_ack_o &&
                      wb_dat_o == 32'h0 && timeout_select == 3'h0 &&
                      poweron_segment_mask == 4'h0 && poweroff_segment_mask == 4'h0 &&
                      bypass_mode_sel == LBW_MODE_NONE))
    else $error("register not zero after reset");

  a_ack_follows_req: assert property (
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  a_tmr_read_flag: assert property (
    s_tmr_read |=> wb_dat_o == (32'($past(timer_expired)) << `LBW_EXP_BIT))
    else $error("timer read did not return expired flag");

  a_read_data_zero: assert property (
    s_other_read |=> wb_dat_o == 32'h0)
    else $error("read of write-only register returned data");

  a_read_keeps_relay: assert property (
    (req && !wb_we_i && system_powered && !expire) |=> $stable(relay_close))
    else $error("read moved a relay");

  a_powered_relay_hold: assert property (
    (system_powered && !wr_pon && !expire) |=> $stable(relay_close))
    else $error("relay moved without write or expiry");

  a_zero_write_idle: assert property (
    s_zero_write |=> wd_state == LBW_WD_IDLE)
    else $error("zero timeout left watchdog running");

  a_restart_run: assert property (
    s_restart_write |=> wd_state == LBW_WD_RUN)
    else $error("timeout write did not start watchdog");

  a_count_in_range: assert property (
    wd_state == LBW_WD_RUN |-> sec_cnt < period_sec(timeout_select))
    else $error("second count beyond period");

  a_tick_wraps: assert property (
    sec_tick |=> tick_cnt == 32'h0)
    else $error("second tick did not wrap");

  a_flag_stays_set: assert property (
    (timer_expired && !wr_tmr) |=> timer_expired)
    else $error("expired flag dropped without write");

  a_ack_one_cycle: assert property (
    (req ##1 wb_ack_o) |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule // lbw_top
`default_nettype wire

/* test_lan_bypass_relay_watchdog.sv */
// Self-checking testbench of the LAN bypass relay watchdog
`default_nettype none
`include "lbw_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_lan_bypass_relay_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  import lbw_pkg::*;

  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam int          TICK   = 20;
  localparam logic [15:0] A_PON  = 16'(`LBW_IDX_PON * 4);
  localparam logic [15:0] A_POFF = 16'(`LBW_IDX_POFF * 4);
  localparam logic [15:0] A_TMR  = 16'(`LBW_IDX_TMR * 4);
  localparam logic [15:0] A_BAD  = 16'h2390;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        pwr = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  bsel = 4'hf;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack;
  lbw_seg_t    relay;
  logic        timer_expired_flag;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          rl = 0;
  int          pon = 0;
  int          poff = 0;
  int          n;
  int          m;

  always #12.5 clk = ~clk;

  lbw_top #(.TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .reset(reset), .system_powered(pwr),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .relay_close(relay), .timer_expired(timer_expired_flag)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Classic single cycle, entered just after a rising edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= bsel;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 40);
    if (ack !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr_pon(input int md, input int mk);
    bus(1'b1, A_PON, 8'((md << 6) | mk));
    pon = mk;
    if (md == 1) rl |= mk;
    else if (md == 2) rl &= ~mk;
  endtask

  task automatic wait_exp(input int p);
    n = 0;
    while (timer_expired_flag !== 1'b1 && n < p + 10) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= p - 3 && n <= p + 1, 1'b1)
    if (timer_expired_flag !== 1'b1) begin
      print_verdict();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h959b));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, A_TMR, 8'h00);
    `CHK(q[7], 1'b0)
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(relay, 4'h0)
    pwr <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      wr_pon(k % 4, $urandom % 16);
      `CHK(relay, 4'(rl))
    end
    bus(1'b0, A_PON, 8'h00);
    bus(1'b0, A_POFF, 8'h00);
    bus(1'b1, A_BAD, 8'hff);
    bus(1'b0, A_BAD, 8'h00);
    `CHK(relay, 4'(rl))
    bus(1'b1, A_TMR, 8'h00);
    repeat (200) @(posedge clk);
    `CHK(timer_expired_flag, 1'b0)
    for (int k = 1; k < 8; k++) begin
      wr_pon(2, 15);
      wr_pon(3, 1 + $urandom % 15);
      bus(1'b1, A_TMR, 8'(k));
      `CHK(timer_expired_flag, 1'b0)
      wait_exp((1 << (k - 1)) * TICK);
      rl |= pon;
      `CHK(relay, 4'(rl))
      bus(1'b0, A_TMR, 8'h00);
      `CHK(q[7], 1'b1)
    end
    bus(1'b1, A_TMR, 8'h02);
    repeat (5) begin
      repeat (25) @(posedge clk);
      bus(1'b1, A_TMR, 8'h02);
    end
    `CHK(timer_expired_flag, 1'b0)
    n = 0;
    // One cycle of slack puts a read on the expiry tick
    @(posedge clk);
    while (timer_expired_flag !== 1'b1 && n < 30) begin
      bus(1'b0, A_TMR, 8'h00);
      n++;
    end
    `CHK(n >= 12 && n <= 15, 1'b1)
    if (timer_expired_flag !== 1'b1) begin
      print_verdict();
    end
    wr_pon(3, 15);
    poff = $urandom % 15;
    bus(1'b1, A_POFF, 8'(poff));
    bsel = 4'he;
    bus(1'b1, A_POFF, 8'h0f);
    bsel = 4'hf;
    pwr <= 1'b0;
    pon = 0;
    repeat (3) @(posedge clk);
    `CHK(relay, 4'(poff))
    rl = poff;
    pwr <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(relay, 4'(rl))
    bus(1'b1, A_TMR, 8'h01);
    wait_exp(TICK);
    rl |= pon;
    `CHK(relay, 4'(rl))
    wr_pon(1, 5);
    `CHK(relay, 4'(rl))
    wr_pon(2, 15);
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(relay, 4'(poff))
    print_verdict();
  end
endmodule // test_lan_bypass_relay_watchdog
`default_nettype wire
